/* psr_params.svh */
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH
// Channel count and reading format
`define PSR_NCH      6
`define PSR_MANT_W   10
`define PSR_EXP_W    6
`define PSR_HYST_DIV 11'h00a
`define PSR_MANT_MIN 11'h064
`define PSR_MANT_MAX 11'h3e7
// Ion gauge assignment codes
`define PSR_ASG_EITHER 2'h0
`define PSR_ASG_ONE    2'h1
`define PSR_ASG_TWO    2'h2
`define PSR_ASG_NONE   2'h3
// Channel indexes
`define PSR_CH_ION1 0
`define PSR_CH_ION2 1
`define PSR_CH_TCA0 2
`define PSR_CH_TCB0 4
`endif

/* psr_pkg.sv */
`default_nettype none
`include "psr_params.svh"
package psr_pkg;
  typedef logic        [`PSR_MANT_W-1:0] psr_mant_t;
  typedef logic signed [`PSR_EXP_W-1:0]  psr_exp_t;
  // Relay state, one-hot
  typedef enum logic [1:0] {
    PSR_OFF = 2'h1,
    PSR_ON  = 2'h2
  } psr_state_e;
  // Ion gauge assignment per channel
  typedef enum logic [1:0] {
    PSR_EITHER = `PSR_ASG_EITHER,
    PSR_ONE    = `PSR_ASG_ONE,
    PSR_TWO    = `PSR_ASG_TWO,
    PSR_NONE   = `PSR_ASG_NONE
  } psr_assign_e;
endpackage
`default_nettype wire

/* psr_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface psr_chan_if;
  import psr_pkg::*;
  psr_mant_t mant;
  psr_exp_t  expo;
  logic      valid;
  logic      enable;
  logic      pol_above;
  logic      ovr_on;
  logic      ovr_off;
  psr_mant_t sp_mant;
  psr_exp_t  sp_exp;
  logic      relay;
  modport top  (output mant, expo, valid, enable, pol_above, ovr_on, ovr_off, sp_mant, sp_exp,
                input relay);
  modport chan (input mant, expo, valid, enable, pol_above, ovr_on, ovr_off, sp_mant, sp_exp,
                output relay);
endinterface
`default_nettype wire

/* psr_chan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"
module psr_chan
  import psr_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic nrst_i,
  psr_chan_if.chan  ch
);
  // ***************************
  // Thresholds
  // ***************************
  // Compare reading A below B
  function automatic logic lt(input logic [10:0] am, input psr_exp_t ae,
                              input logic [10:0] bm, input psr_exp_t be);
    lt = (ae < be) || ((ae == be) && (am < bm));
  endfunction

  // Upper and lower hysteresis points, renormalised to three digits
  wire logic [10:0] sp_m    = {1'b0, ch.sp_mant};
  wire logic [10:0] tenth   = sp_m / `PSR_HYST_DIV;
  wire logic [10:0] hi_raw  = sp_m + tenth;
  wire logic [10:0] lo_raw  = sp_m - tenth;
  wire logic        hi_wrap = hi_raw > `PSR_MANT_MAX;
  wire logic        lo_wrap = lo_raw < `PSR_MANT_MIN;
  wire logic [10:0] hi_m    = hi_wrap ? hi_raw / `PSR_HYST_DIV : hi_raw;
  wire psr_exp_t    hi_e    = hi_wrap ? ch.sp_exp + psr_exp_t'(1) : ch.sp_exp;
  // Lower point renormalises exactly; only the upper point loses its last digit; accepted
  wire logic [10:0] lo_m    = lo_wrap ? 11'(lo_raw * `PSR_HYST_DIV) : lo_raw;
  wire psr_exp_t    lo_e    = lo_wrap ? ch.sp_exp - psr_exp_t'(1) : ch.sp_exp;
  wire logic [10:0] p_m     = {1'b0, ch.mant};

  // ***************************
  // Decisions
  // ***************************
  // One display unit past the setpoint actuates
  wire logic below_sp = lt(p_m, ch.expo, sp_m, ch.sp_exp);
  wire logic above_sp = lt(sp_m, ch.sp_exp, p_m, ch.expo);
  wire logic act      = ch.pol_above ? above_sp : below_sp;
  // Returning pressure must cross the 10% band
  wire logic rel      = ch.pol_above ? !lt(lo_m, lo_e, p_m, ch.expo)
                                     : !lt(p_m, ch.expo, hi_m, hi_e);

  psr_state_e state_q;
  psr_state_e state_d;
  logic       relay_q;
  wire logic  relay_d;

  // Next state; only a fresh reading can energise
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSR_OFF: begin
        if (ch.enable && ch.valid && act) state_d = PSR_ON;
      end
      PSR_ON: begin
        if (!ch.enable) state_d = PSR_OFF;
        else if (ch.valid && rel) state_d = PSR_OFF;
      end
      default: state_d = PSR_OFF;
    endcase
  end

  // Off override wins: fail-safe when both are set
  assign relay_d = ch.ovr_off ? 1'b0 : (ch.ovr_on ? 1'b1 : (state_d == PSR_ON));

  // State and relay flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= PSR_OFF;
      relay_q <= 1'b0;
    end else begin
      state_q <= state_d;
      relay_q <= relay_d;
    end
  end

  assign ch.relay = relay_q;

  // ***************************
  // Checks
  // ***************************
  wire logic no_ovr = !ch.ovr_on && !ch.ovr_off;

  property p_ovr_off;
    @(posedge clock_i) disable iff (!nrst_i) ch.ovr_off |=> !ch.relay;
  endproperty
  a_ovr_off: assert property (p_ovr_off) else $error("override off ignored");

  property p_ovr_on;
    @(posedge clock_i) disable iff (!nrst_i) (ch.ovr_on && !ch.ovr_off) |=> ch.relay;
  endproperty
  a_ovr_on: assert property (p_ovr_on) else $error("override on ignored");

  property p_act_below;
    @(posedge clock_i) disable iff (!nrst_i)
      (ch.enable && ch.valid && !ch.pol_above && below_sp && no_ovr) |=> ch.relay;
  endproperty
  a_act_below: assert property (p_act_below) else $error("no actuation below");

  property p_act_above;
    @(posedge clock_i) disable iff (!nrst_i)
      (ch.enable && ch.valid && ch.pol_above && above_sp && no_ovr) |=> ch.relay;
  endproperty
  a_act_above: assert property (p_act_above) else $error("no actuation above");

  property p_hyst_hold;
    @(posedge clock_i) disable iff (!nrst_i)
      (ch.relay && ch.enable && !ch.pol_above && !below_sp && !rel && no_ovr) |=> ch.relay;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("released inside band");

  property p_release;
    @(posedge clock_i) disable iff (!nrst_i)
      (ch.valid && !ch.pol_above && rel && no_ovr) |=> !ch.relay;
  endproperty
  a_release: assert property (p_release) else $error("no release past band");

  property p_gate;
    @(posedge clock_i) disable iff (!nrst_i) (!ch.enable && !ch.ovr_on) |=> !ch.relay;
  endproperty
  a_gate: assert property (p_gate) else $error("relay on while inoperative");

  property p_fresh;
    @(posedge clock_i) disable iff (!nrst_i)
      (!ch.relay && !ch.valid && !ch.ovr_on) |=> !ch.relay;
  endproperty
  a_fresh: assert property (p_fresh) else $error("energised without reading");

  c_act:   cover property (@(posedge clock_i) disable iff (!nrst_i) !ch.relay ##1 ch.relay);
  c_rel:   cover property (@(posedge clock_i) disable iff (!nrst_i)
                           ch.relay && no_ovr ##1 !ch.relay);
  c_above: cover property (@(posedge clock_i) disable iff (!nrst_i) ch.pol_above && ch.relay);
endmodule // psr_chan
`default_nettype wire

/* psr_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"
module psr_top
  import psr_pkg::*;
(
  input  wire logic                                clock_i,
  input  wire logic                                nrst_i,
  input  wire logic                                ion_gauge_one_on_i,
  input  wire logic                                ion_gauge_two_on_i,
  input  wire logic                                degas_i,
  input  wire psr_mant_t                           ion_mant_i,
  input  wire psr_exp_t                            ion_exp_i,
  input  wire logic                                ion_valid_i,
  input  wire logic                                tc_a_conn_i,
  input  wire psr_mant_t                           tc_a_mant_i,
  input  wire psr_exp_t                            tc_a_exp_i,
  input  wire logic                                tc_a_valid_i,
  input  wire logic                                tc_b_conn_i,
  input  wire psr_mant_t                           tc_b_mant_i,
  input  wire psr_exp_t                            tc_b_exp_i,
  input  wire logic                                tc_b_valid_i,
  input  wire psr_assign_e                         assign_one_i,
  input  wire psr_assign_e                         assign_two_i,
  input  wire logic [`PSR_NCH-1:0]                 pol_above_i,
  input  wire logic [`PSR_NCH-1:0]                 ovr_on_i,
  input  wire logic [`PSR_NCH-1:0]                 ovr_off_i,
  input  wire logic [`PSR_NCH-1:0][`PSR_MANT_W-1:0] sp_mant_i,
  input  wire logic [`PSR_NCH-1:0][`PSR_EXP_W-1:0]  sp_exp_i,
  output logic      [`PSR_NCH-1:0]                 relay_o
);
  // ***************************
  // Degas freeze
  // ***************************
  logic      degas_q;
  psr_mant_t frz_mant_q;
  psr_exp_t  frz_exp_q;
  wire logic degas_rise = degas_i && !degas_q;
  wire logic frozen     = degas_i && degas_q;

  // Capture the reading in the cycle degas starts
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      degas_q    <= 1'b0;
      frz_mant_q <= '0;
      frz_exp_q  <= '0;
    end else begin
      degas_q <= degas_i;
      if (degas_rise) begin
        frz_mant_q <= ion_mant_i;
        frz_exp_q  <= ion_exp_i;
      end
    end
  end

  // Ion channels see the frozen value while degas lasts
  wire psr_mant_t ion_mant = frozen ? frz_mant_q : ion_mant_i;
  wire psr_exp_t  ion_exp  = frozen ? frz_exp_q : ion_exp_i;

  // ***************************
  // Ion gauge gating
  // ***************************
  function automatic logic ion_gate(input psr_assign_e mode, input logic g1, input logic g2);
    case (mode)
      PSR_EITHER: ion_gate = g1 || g2;
      PSR_ONE:    ion_gate = g1 && !g2;
      PSR_TWO:    ion_gate = g2 && !g1;
      PSR_NONE:   ion_gate = 1'b0;
      default:    ion_gate = 1'b0;
    endcase
  endfunction

  // Every mode yields off with both gauges off
  wire logic en_one = ion_gate(assign_one_i, ion_gauge_one_on_i, ion_gauge_two_on_i);
  wire logic en_two = ion_gate(assign_two_i, ion_gauge_one_on_i, ion_gauge_two_on_i);

  // ***************************
  // Channels
  // ***************************
  psr_chan_if chif [`PSR_NCH] ();

  genvar i;
  generate
    for (i = 0; i < `PSR_NCH; i++) begin : g_ch
      // Source routing is fixed per channel index
      localparam bit IS_ION = (i < `PSR_CH_TCA0);
      localparam bit IS_TCA = (i >= `PSR_CH_TCA0) && (i < `PSR_CH_TCB0);
      assign chif[i].mant    = IS_ION ? ion_mant :
                               (IS_TCA ? tc_a_mant_i : tc_b_mant_i);
      assign chif[i].expo    = IS_ION ? ion_exp :
                               (IS_TCA ? tc_a_exp_i : tc_b_exp_i);
      assign chif[i].valid   = IS_ION ? ion_valid_i :
                               (IS_TCA ? tc_a_valid_i : tc_b_valid_i);
      assign chif[i].enable  = IS_ION ? ((i == `PSR_CH_ION1) ? en_one : en_two) :
                               (IS_TCA ? tc_a_conn_i : tc_b_conn_i);
      // Switch low means below, the default
      assign chif[i].pol_above = pol_above_i[i];
      assign chif[i].ovr_on    = ovr_on_i[i];
      assign chif[i].ovr_off   = ovr_off_i[i];
      assign chif[i].sp_mant   = sp_mant_i[i];
      assign chif[i].sp_exp    = sp_exp_i[i];
      assign relay_o[i]        = chif[i].relay;

      psr_chan u_chan (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .ch      (chif[i])
      );
    end
  endgenerate

  // ***************************
  // Checks
  // ***************************
  property p_never;
    @(posedge clock_i) disable iff (!nrst_i)
      (assign_one_i == PSR_NONE && !ovr_on_i[`PSR_CH_ION1]) |=> !relay_o[`PSR_CH_ION1];
  endproperty
  a_never: assert property (p_never) else $error("disabled channel energised");

  property p_ion_off;
    @(posedge clock_i) disable iff (!nrst_i)
      (!ion_gauge_one_on_i && !ion_gauge_two_on_i && !ovr_on_i[`PSR_CH_ION2])
        |=> !relay_o[`PSR_CH_ION2];
  endproperty
  a_ion_off: assert property (p_ion_off) else $error("ion channel on, gauges off");

  property p_block_two;
    @(posedge clock_i) disable iff (!nrst_i)
      (assign_one_i == PSR_ONE && ion_gauge_two_on_i && !ovr_on_i[`PSR_CH_ION1])
        |=> !relay_o[`PSR_CH_ION1];
  endproperty
  a_block_two: assert property (p_block_two) else $error("gauge two did not block");

  property p_freeze;
    @(posedge clock_i) disable iff (!nrst_i)
      degas_rise ##1 degas_i |-> (chif[`PSR_CH_ION1].mant == $past(ion_mant_i));
  endproperty
  a_freeze: assert property (p_freeze) else $error("reading not frozen in degas");

  property p_tc_off;
    @(posedge clock_i) disable iff (!nrst_i)
      (!tc_b_conn_i && !ovr_on_i[`PSR_CH_TCB0]) |=> !relay_o[`PSR_CH_TCB0];
  endproperty
  a_tc_off: assert property (p_tc_off) else $error("thermal channel on, gauge gone");

  // ***************************
  // Gating checks
  // ***************************
  // Gauge one blocks channel one in the third assignment
  property p_g1_blk1;
    @(posedge clock_i) disable iff (!nrst_i)
      (assign_one_i == PSR_TWO && ion_gauge_one_on_i && !ovr_on_i[`PSR_CH_ION1])
        |=> !relay_o[`PSR_CH_ION1];
  endproperty
  a_g1_blk1: assert property (p_g1_blk1) else $error("gauge one did not block");

  // Same table applies to channel two, on its own switch
  property p_g2_blk2;
    @(posedge clock_i) disable iff (!nrst_i)
      (assign_two_i == PSR_ONE && ion_gauge_two_on_i && !ovr_on_i[`PSR_CH_ION2])
        |=> !relay_o[`PSR_CH_ION2];
  endproperty
  a_g2_blk2: assert property (p_g2_blk2) else $error("gauge two let channel two on");

  // Gauge one blocks channel two in the third assignment
  property p_g1_blk2;
    @(posedge clock_i) disable iff (!nrst_i)
      (assign_two_i == PSR_TWO && ion_gauge_one_on_i && !ovr_on_i[`PSR_CH_ION2])
        |=> !relay_o[`PSR_CH_ION2];
  endproperty
  a_g1_blk2: assert property (p_g1_blk2) else $error("gauge one let channel two on");

  // Fourth assignment on channel two
  property p_never2;
    @(posedge clock_i) disable iff (!nrst_i)
      (assign_two_i == PSR_NONE && !ovr_on_i[`PSR_CH_ION2]) |=> !relay_o[`PSR_CH_ION2];
  endproperty
  a_never2: assert property (p_never2) else $error("disabled channel two energised");

  // Both gauges off silences channel one too
  property p_ion_off1;
    @(posedge clock_i) disable iff (!nrst_i)
      (!ion_gauge_one_on_i && !ion_gauge_two_on_i && !ovr_on_i[`PSR_CH_ION1])
        |=> !relay_o[`PSR_CH_ION1];
  endproperty
  a_ion_off1: assert property (p_ion_off1) else $error("channel one on, gauges off");

  // Gauge A gone silences its first channel
  property p_tca_off;
    @(posedge clock_i) disable iff (!nrst_i)
      (!tc_a_conn_i && !ovr_on_i[`PSR_CH_TCA0]) |=> !relay_o[`PSR_CH_TCA0];
  endproperty
  a_tca_off: assert property (p_tca_off) else $error("channel three on, gauge A gone");

  // Live input may move freely; the channel must not see it while degas lasts
  property p_frz_hold;
    @(posedge clock_i) disable iff (!nrst_i)
      frozen |-> ($stable(chif[`PSR_CH_ION2].mant) && $stable(chif[`PSR_CH_ION2].expo));
  endproperty
  a_frz_hold: assert property (p_frz_hold) else $error("frozen reading moved");

  c_degas: cover property (@(posedge clock_i) disable iff (!nrst_i)
                           frozen && relay_o[`PSR_CH_ION1]);
  c_tc:    cover property (@(posedge clock_i) disable iff (!nrst_i) relay_o[`PSR_CH_TCA0]);
endmodule // psr_top
`default_nettype wire

/* psr_equip.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"
// ****************************************************************
// Process equipment wired to the relay contacts
// ****************************************************************
module psr_equip
  import psr_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                nrst_i,
  input  wire logic [`PSR_NCH-1:0] relay_i,
  output logic      [`PSR_NCH-1:0] eq_on_o
);
  // Contacts seen one cycle late, as a slow load would respond
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      eq_on_o <= {`PSR_NCH{1'b0}};
    end else begin
      eq_on_o <= relay_i;
    end
  end
endmodule // psr_equip
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"
module tb_top
  import psr_pkg::*;
;
  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  localparam psr_exp_t E6 = 6'h3a;
  localparam psr_exp_t E7 = 6'h39;
  localparam psr_exp_t E8 = 6'h38;
  logic                                  clock_i = 1'b0;
  logic                                  nrst_i = 1'b0;
  logic                                  ion_gauge_one_on, ion_gauge_two_on, degas, ion_valid;
  logic                                  tc_a_conn, tc_a_valid, tc_b_conn, tc_b_valid;
  psr_mant_t                             ion_mant, tc_a_mant, tc_b_mant;
  psr_exp_t                              ion_exp, tc_a_exp, tc_b_exp;
  psr_assign_e                           assign_one, assign_two;
  logic [`PSR_NCH-1:0]                   pol_above, ovr_on, ovr_off, relay, eq_on;
  logic [`PSR_NCH-1:0][`PSR_MANT_W-1:0]  sp_mant;
  logic [`PSR_NCH-1:0][`PSR_EXP_W-1:0]   sp_exp;
  int                                    errors = 0;
  int                                    checks = 0;
  int                                    cycles = 0;

  psr_top dut_u (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .ion_gauge_one_on_i(ion_gauge_one_on), .ion_gauge_two_on_i(ion_gauge_two_on),
    .degas_i(degas), .ion_mant_i(ion_mant), .ion_exp_i(ion_exp), .ion_valid_i(ion_valid),
    .tc_a_conn_i(tc_a_conn), .tc_a_mant_i(tc_a_mant), .tc_a_exp_i(tc_a_exp),
    .tc_a_valid_i(tc_a_valid), .tc_b_conn_i(tc_b_conn), .tc_b_mant_i(tc_b_mant),
    .tc_b_exp_i(tc_b_exp), .tc_b_valid_i(tc_b_valid), .assign_one_i(assign_one),
    .assign_two_i(assign_two), .pol_above_i(pol_above), .ovr_on_i(ovr_on),
    .ovr_off_i(ovr_off), .sp_mant_i(sp_mant), .sp_exp_i(sp_exp), .relay_o(relay)
  );
  psr_equip equip_u (.clock_i(clock_i), .nrst_i(nrst_i), .relay_i(relay), .eq_on_o(eq_on));

  // ****************************************************************
  // Clock, hang guard and shared tasks
  // ****************************************************************
  always #20 clock_i = ~clock_i;

  // Whole run needs well under a thousand cycles; cut off a hang
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic seen, input logic expv, input string msg);
    checks = checks + 1;
    if (seen !== expv) begin
      errors = errors + 1;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Readings are held valid as a level; three cycles covers the relay latency
  task automatic reading(input int src, input psr_mant_t m, input psr_exp_t e);
    case (src)
      0: begin ion_mant = m; ion_exp = e; end
      1: begin tc_a_mant = m; tc_a_exp = e; end
      default: begin tc_b_mant = m; tc_b_exp = e; end
    endcase
    wait_n(3);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    wait_n(1);
    for (int i = 0; i < `PSR_NCH; i++) chk(relay[i], 1'b0, "relay on after reset");
    ion_gauge_one_on = 1'b1;
    ion_valid = 1'b1;
    reading(0, 10'h384, E6);
    chk(relay[0], 1'b0, "high pressure energised relay");
    reading(0, 10'h1f4, E7);
    chk(relay[0], 1'b1, "low pressure did not energise");
    // Reading withheld across release: nothing may energise until one arrives
    nrst_i = 1'b0;
    ion_valid = 1'b0;
    wait_n(1);
    chk(relay[0], 1'b0, "relay held through reset");
    nrst_i = 1'b1;
    wait_n(2);
    chk(relay[0], 1'b0, "relay on without a reading");
    ion_valid = 1'b1;
    wait_n(1);
    chk(relay[0], 1'b1, "first reading after reset ignored");
    ion_gauge_one_on = 1'b0;
    wait_n(3);
  endtask

  task automatic test_thresh();
    pol_above[3] = 1'b1;
    tc_a_conn = 1'b1;
    tc_a_valid = 1'b1;
    reading(1, 10'h276, E7);
    chk(relay[2], 1'b0, "on at setpoint itself");
    chk(relay[3], 1'b0, "above channel on at setpoint");
    reading(1, 10'h275, E7);
    chk(relay[2], 1'b1, "not on one unit below");
    chk(relay[4], 1'b0, "gauge B channel follows gauge A");
    reading(1, 10'h2b4, E7);
    chk(relay[2], 1'b1, "released inside hysteresis");
    reading(1, 10'h2b5, E7);
    chk(relay[2], 1'b0, "held past setpoint plus tenth");
    chk(relay[3], 1'b1, "above channel not on");
    reading(1, 10'h238, E7);
    chk(relay[3], 1'b1, "above channel released early");
    chk(relay[2], 1'b1, "below channel not on");
    reading(1, 10'h237, E7);
    chk(relay[3], 1'b0, "above channel held past release");
    tc_a_conn = 1'b0;
    wait_n(3);
    chk(relay[2], 1'b0, "disconnected gauge A left relay on");
  endtask

  task automatic test_tcb();
    tc_b_conn = 1'b1;
    tc_b_valid = 1'b1;
    reading(2, 10'h384, E8);
    chk(relay[4], 1'b1, "gauge B channel five idle");
    chk(relay[5], 1'b1, "gauge B channel six idle");
    chk(relay[2], 1'b0, "gauge A channel follows gauge B");
    reading(2, 10'h064, E6);
    chk(relay[5], 1'b0, "held above release point");
    reading(2, 10'h384, E8);
    tc_b_conn = 1'b0;
    wait_n(3);
    chk(relay[4], 1'b0, "disconnected gauge B left relay on");
    chk(relay[5], 1'b0, "disconnected gauge B left relay on");
  endtask

  task automatic test_assign();
    logic expv;
    ion_mant = 10'h1f4;
    ion_exp = E7;
    for (int a = 0; a < 4; a++) begin
      assign_one = psr_assign_e'(a[1:0]);
      assign_two = psr_assign_e'(a[1:0]);
      for (int g = 0; g < 4; g++) begin
        ion_gauge_one_on = g[0];
        ion_gauge_two_on = g[1];
        wait_n(3);
        case (a)
          0: expv = g[0] | g[1];
          1: expv = g[0] & ~g[1];
          2: expv = g[1] & ~g[0];
          default: expv = 1'b0;
        endcase
        chk(relay[0], expv, "channel one gating");
        chk(relay[1], expv, "channel two gating");
      end
    end
    assign_one = PSR_EITHER;
    assign_two = PSR_EITHER;
  endtask

  task automatic test_override();
    ovr_on[5] = 1'b1;
    wait_n(3);
    chk(relay[5], 1'b1, "override on ignored");
    chk(eq_on[5], 1'b1, "equipment did not see contact");
    ovr_off[5] = 1'b1;
    wait_n(3);
    chk(relay[5], 1'b0, "override off lost to on");
    ovr_on[5] = 1'b0;
    ovr_off[5] = 1'b0;
    ovr_off[0] = 1'b1;
    wait_n(3);
    chk(relay[0], 1'b0, "override off ignored");
    ovr_off[0] = 1'b0;
    wait_n(3);
    chk(relay[0], 1'b1, "relay not back after override");
  endtask

  // Degas freezes only the ion reading; the freeze must work both ways
  task automatic test_degas();
    degas = 1'b1;
    wait_n(1);
    reading(0, 10'h384, E6);
    chk(relay[0], 1'b1, "relay one moved in degas");
    chk(relay[1], 1'b1, "relay two moved in degas");
    degas = 1'b0;
    wait_n(3);
    chk(relay[0], 1'b0, "relay stuck after degas");
    degas = 1'b1;
    wait_n(1);
    reading(0, 10'h1f4, E7);
    chk(relay[1], 1'b0, "relay two moved in degas");
    degas = 1'b0;
    wait_n(3);
    chk(relay[1], 1'b1, "relay stuck after degas");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {ion_gauge_one_on, ion_gauge_two_on, degas, ion_valid} = 4'h0;
    {tc_a_conn, tc_a_valid, tc_b_conn, tc_b_valid} = 4'h0;
    {ion_mant, tc_a_mant, tc_b_mant} = {10'h384, 10'h384, 10'h384};
    {ion_exp, tc_a_exp, tc_b_exp} = {E6, E6, E6};
    assign_one = PSR_EITHER;
    assign_two = PSR_EITHER;
    pol_above = 6'h00;
    ovr_on = 6'h00;
    ovr_off = 6'h00;
    for (int i = 0; i < `PSR_NCH; i++) begin
      sp_mant[i] = 10'h276;
      sp_exp[i] = E7;
    end
    repeat (5) @(negedge clock_i);
    nrst_i = 1'b1;
    test_reset();
    test_thresh();
    test_tcb();
    test_assign();
    ion_gauge_one_on = 1'b1;
    test_override();
    test_degas();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
